// file: core/hlpf_framer.sv
// host link packet framer: interface pick, link and transport framing, acknowledge
`timescale 1ns/10ps
// How it works
// - pick UART or SPI once, keep until reset
// - UART 8 data, no parity, 1 stop, lsb
// - UART runs at 115200 baud
// - SPI mode 0, chip select active low
// - SPI clock up to 20 MHz; sclk is sampled by the 20 MHz system clock, so only below 10 MHz
// - SPI interrupt while response data waits
// - no transfer above 256 byte buffer
// - answer each packet with 7F FF 01 7F
// - acknowledge sent raw, unframed
// - acknowledge every packet, report errors, no retry
// - frame: channel, size, payload, 4-byte CRC
// - send channel zero, ignore it on receive
// - size counts payload bytes only
// - CRC over payload only, mismatch is error
// - segments carry at most 242 payload bytes
// - segment header: size, chunk index, length
// - chunk index starts at 1, rises by one
// - message complete when last chunk arrives
// - transport errors passed up, no recovery
// - application data passes as clear text
// - message: command, arg count, key/size/payload args
module hlpf_framer import hlpf_pkg::*; #(
  parameter int DIV = BAUD_DIV
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // uart pins
  input wire logic uart_rxd,
  output logic uart_txd,
  // spi pins
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  output logic spi_miso,
  output logic spi_miso_oe,
  output logic irq,
  // received segment bytes and events
  output hlpf_byte_s rx_byte,
  output logic msg_done,
  output logic rx_err,
  output hlpf_sel_e if_sel,
  // segment transmit
  input wire logic seg_start,
  input wire hlpf_seg_s seg,
  input wire logic usr_tx_valid,
  input wire logic [7:0] usr_tx_data,
  output logic usr_tx_ready,
  output logic tx_busy
);
  typedef enum logic [2:0] {R_CHAN, R_SIZE, R_PAY, R_CRC, R_CHK, R_REL} hlpf_rx_e;
  typedef enum logic [2:0] {T_IDLE, T_ACK, T_HDR, T_DATA, T_CRC} hlpf_tx_e;

  function automatic logic [7:0] hdr_byte(input hlpf_seg_s s, input logic [3:0] i);
    logic [15:0] lsize;
    lsize = s.len + 16'(TP_HDR);
    case (i)
      4'h2: hdr_byte = lsize[7:0];
      4'h3: hdr_byte = lsize[15:8];
      4'h4: hdr_byte = s.len[7:0];
      4'h5: hdr_byte = s.len[15:8];
      4'h6: hdr_byte = s.nr[7:0];
      4'h7: hdr_byte = s.nr[15:8];
      4'h8: hdr_byte = s.total[7:0];
      4'h9: hdr_byte = s.total[15:8];
      default: hdr_byte = CHAN_BYTE;
    endcase
  endfunction

  function automatic logic [7:0] ack_byte(input logic [1:0] i);
    case (i)
      2'h0: ack_byte = ACK_B0;
      2'h1: ack_byte = ACK_B1;
      2'h2: ack_byte = ACK_B2;
      default: ack_byte = ACK_B3;
    endcase
  endfunction

  hlpf_sel_e sel_q;
  hlpf_rx_e rst_q;
  hlpf_tx_e tst_q;
  logic [7:0] buf_q [BUF_BYTES];
  logic [15:0] cnt_q;
  logic [15:0] len_q;
  logic over_q;
  logic [31:0] crc_q;
  logic [31:0] rcrc_q;
  logic [15:0] exp_q;
  logic [15:0] rel_q;
  logic ack_q;
  logic [15:0] tcnt_q;
  hlpf_seg_s seg_q;
  logic [31:0] tcrc_q;
  logic txv_q;
  logic [7:0] txb_q;

  // physical layer
  logic u_rx_v;
  logic [7:0] u_rx_d;
  logic u_rdy;
  logic s_rx_v;
  logic [7:0] s_rx_d;
  logic s_load;
  wire is_uart = sel_q == SEL_UART;
  wire is_spi = sel_q == SEL_SPI;
  wire [7:0] spi_tx = txv_q ? txb_q : SPI_IDLE_BYTE;

  hlpf_uart #(.DIV(DIV)) u_uart (
    .clk(clk),
    .nrst(nrst),
    .rxd(uart_rxd),
    .txd(uart_txd),
    .rx_valid(u_rx_v),
    .rx_data(u_rx_d),
    .tx_valid(txv_q && is_uart),
    .tx_data(txb_q),
    .tx_ready(u_rdy)
  );

  hlpf_spi u_spi (
    .clk(clk),
    .nrst(nrst),
    .sclk(spi_sclk),
    .cs_n(spi_cs_n),
    .mosi(spi_mosi),
    .miso(spi_miso),
    .miso_oe(spi_miso_oe),
    .rx_valid(s_rx_v),
    .rx_data(s_rx_d),
    .tx_data(spi_tx),
    .tx_load(s_load)
  );

  // byte in, byte out of the chosen interface
  wire rx_v = (is_uart && u_rx_v) || (is_spi && s_rx_v);
  wire [7:0] rx_d = is_spi ? s_rx_d : u_rx_d;
  wire take = txv_q && ((is_uart && u_rdy) || (is_spi && s_load));
  wire free = !txv_q || take;

  // receive decode
  wire [15:0] size_full = {rx_d, len_q[7:0]};
  wire [15:0] tp_size = {buf_q[1], buf_q[0]};
  wire [15:0] tp_nr = {buf_q[3], buf_q[2]};
  wire [15:0] tp_len = {buf_q[5], buf_q[4]};
  wire crc_ok = (crc_q ^ CRC_XOROUT) == rcrc_q;
  wire link_ok = crc_ok && !over_q;
  wire tp_ok = len_q >= 16'(TP_HDR) && tp_size + 16'(TP_HDR) == len_q
    && tp_size <= 16'(SEG_MAX) && tp_nr == exp_q && tp_nr <= tp_len;
  wire rel_end = rel_q >= len_q;
  wire tp_last = tp_nr == tp_len;
  wire pay_last = cnt_q == len_q - 16'h0001;
  wire ack_set = rx_v && rst_q == R_CRC && cnt_q == 16'h0003;
  wire ack_clr = tst_q == T_IDLE && !seg_start && ack_q;

  // interface choice holds until the next reset
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sel_q <= SEL_NONE;
    end else if (sel_q == SEL_NONE) begin
      if (!spi_cs_n) begin
        sel_q <= SEL_SPI;
      end else if (!uart_rxd) begin
        sel_q <= SEL_UART;
      end
    end
  end

  // payload store, no reset needed
  always_ff @(posedge clk) begin
    if (rx_v && rst_q == R_PAY && !over_q) begin
      buf_q[cnt_q[7:0]] <= rx_d;
    end
  end

  // link layer parse
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_q <= R_CHAN;
      cnt_q <= 16'h0000;
      len_q <= 16'h0000;
      over_q <= 1'b0;
      crc_q <= CRC_INIT;
      rcrc_q <= 32'h00000000;
    end else if (rx_v) begin
      cnt_q <= cnt_q + 16'h0001;
      case (rst_q)
        R_CHAN: begin
          if (cnt_q == 16'h0001) begin
            rst_q <= R_SIZE;
            cnt_q <= 16'h0000;
          end
        end
        R_SIZE: begin
          if (cnt_q == 16'h0000) begin
            len_q[7:0] <= rx_d;
          end else begin
            len_q <= size_full;
            over_q <= size_full > 16'(PAY_MAX);
            crc_q <= CRC_INIT;
            cnt_q <= 16'h0000;
            rst_q <= size_full == 16'h0000 ? R_CRC : R_PAY;
          end
        end
        R_PAY: begin
          crc_q <= hlpf_crc_byte(crc_q, rx_d);
          if (pay_last) begin
            rst_q <= R_CRC;
            cnt_q <= 16'h0000;
          end
        end
        R_CRC: begin
          rcrc_q <= {rx_d, rcrc_q[31:8]};
          if (cnt_q == 16'h0003) begin
            rst_q <= R_CHK;
          end
        end
        default: ;
      endcase
    end else if (rst_q == R_CHK) begin
      cnt_q <= 16'h0000;
      rst_q <= link_ok && tp_ok ? R_REL : R_CHAN;
    end else if (rst_q == R_REL && rel_end) begin
      rst_q <= R_CHAN;
    end
  end

  // transport layer: check chunk order, release segment payload
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      exp_q <= 16'h0001;
      rel_q <= 16'h0000;
      rx_byte <= '0;
      msg_done <= 1'b0;
      rx_err <= 1'b0;
    end else begin
      rx_byte.valid <= 1'b0;
      msg_done <= 1'b0;
      rx_err <= 1'b0;
      if (rst_q == R_CHK) begin
        rel_q <= 16'(TP_HDR);
        if (!(link_ok && tp_ok)) begin
          rx_err <= 1'b1;
          exp_q <= 16'h0001;
        end
      end else if (rst_q == R_REL) begin
        if (!rel_end) begin
          rx_byte.valid <= 1'b1;
          rx_byte.data <= buf_q[rel_q[7:0]];
          rx_byte.last <= tp_last && rel_q == len_q - 16'h0001;
          rel_q <= rel_q + 16'h0001;
        end else if (tp_last) begin
          msg_done <= 1'b1;
          exp_q <= 16'h0001;
        end else begin
          exp_q <= exp_q + 16'h0001;
        end
      end
    end
  end

  // acknowledge request: a new frame end wins over the clear
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= ack_set || (ack_q && !ack_clr);
    end
  end

  // transmit sequencer
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tst_q <= T_IDLE;
      tcnt_q <= 16'h0000;
      seg_q <= '0;
      tcrc_q <= CRC_INIT;
      txv_q <= 1'b0;
      txb_q <= 8'h00;
    end else begin
      if (take) begin
        txv_q <= 1'b0;
      end
      case (tst_q)
        T_IDLE: begin
          tcnt_q <= 16'h0000;
          tcrc_q <= CRC_INIT;
          if (seg_start) begin
            seg_q <= seg;
            tst_q <= T_HDR;
          end else if (ack_q) begin
            tst_q <= T_ACK;
          end
        end
        T_ACK: begin
          if (free) begin
            txb_q <= ack_byte(tcnt_q[1:0]);
            txv_q <= 1'b1;
            tcnt_q <= tcnt_q + 16'h0001;
            if (tcnt_q == 16'h0003) begin
              tst_q <= T_IDLE;
            end
          end
        end
        T_HDR: begin
          if (free) begin
            txb_q <= hdr_byte(seg_q, tcnt_q[3:0]);
            txv_q <= 1'b1;
            tcnt_q <= tcnt_q + 16'h0001;
            if (tcnt_q >= 16'(LINK_HDR)) begin
              tcrc_q <= hlpf_crc_byte(tcrc_q, hdr_byte(seg_q, tcnt_q[3:0]));
            end
            if (tcnt_q == 16'(TX_HDR_BYTES - 1)) begin
              tcnt_q <= 16'h0000;
              tst_q <= seg_q.len == 16'h0000 ? T_CRC : T_DATA;
            end
          end
        end
        T_DATA: begin
          if (usr_tx_valid && usr_tx_ready) begin
            txb_q <= usr_tx_data;
            txv_q <= 1'b1;
            tcrc_q <= hlpf_crc_byte(tcrc_q, usr_tx_data);
            tcnt_q <= tcnt_q + 16'h0001;
            if (tcnt_q == seg_q.len - 16'h0001) begin
              tcnt_q <= 16'h0000;
              tst_q <= T_CRC;
            end
          end
        end
        T_CRC: begin
          if (free) begin
            txb_q <= 8'((tcrc_q ^ CRC_XOROUT) >> {tcnt_q[1:0], 3'b000});
            txv_q <= 1'b1;
            tcnt_q <= tcnt_q + 16'h0001;
            if (tcnt_q == 16'h0003) begin
              tst_q <= T_IDLE;
            end
          end
        end
        default: tst_q <= T_IDLE;
      endcase
    end
  end

  // user handshake, busy and interrupt
  wire usr_take = usr_tx_valid && usr_tx_ready;
  wire more = tcnt_q + 16'h0001 < seg_q.len;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      usr_tx_ready <= 1'b0;
      tx_busy <= 1'b0;
      irq <= 1'b0;
    end else begin
      usr_tx_ready <= tst_q == T_DATA && free && (usr_take ? 1'b0 : 1'b1)
        && (usr_take ? more : tcnt_q < seg_q.len);
      tx_busy <= tst_q != T_IDLE || seg_start;
      irq <= is_spi && (tst_q != T_IDLE || ack_q || txv_q);
    end
  end

  assign if_sel = sel_q;
endmodule // hlpf_framer

// file: include/hlpf_pkg.sv
// constants, carrier types and crc step for the host link packet framer
package hlpf_pkg;

  // clocking and uart rate
  localparam int CLK_HZ = 20_000_000;
  localparam int UART_BAUD = 115200;
  localparam int BAUD_DIV = (CLK_HZ + UART_BAUD / 2) / UART_BAUD;
  localparam int SPI_SCLK_MAX_HZ = 20_000_000;

  // framing sizes in bytes
  localparam int BUF_BYTES = 256;
  localparam int LINK_HDR = 4;
  localparam int CRC_BYTES = 4;
  localparam int PAY_MAX = BUF_BYTES - LINK_HDR - CRC_BYTES;
  localparam int TP_HDR = 6;
  localparam int SEG_MAX = PAY_MAX - TP_HDR;
  localparam int TX_HDR_BYTES = LINK_HDR + TP_HDR;

  // fixed byte values
  localparam logic [7:0] ACK_B0 = 8'h7f;
  localparam logic [7:0] ACK_B1 = 8'hff;
  localparam logic [7:0] ACK_B2 = 8'h01;
  localparam logic [7:0] ACK_B3 = 8'h7f;
  localparam logic [7:0] CHAN_BYTE = 8'h00;
  localparam logic [7:0] SPI_IDLE_BYTE = 8'h00;

  // reflected crc-32
  localparam logic [31:0] CRC_INIT = 32'hffffffff;
  localparam logic [31:0] CRC_POLY = 32'hedb88320;
  localparam logic [31:0] CRC_XOROUT = 32'hffffffff;

  typedef enum logic [1:0] {SEL_NONE, SEL_UART, SEL_SPI} hlpf_sel_e;

  typedef struct packed {
    logic [15:0] total;
    logic [15:0] nr;
    logic [15:0] len;
  } hlpf_seg_s;

  typedef struct packed {
    logic valid;
    logic last;
    logic [7:0] data;
  } hlpf_byte_s;

  function automatic logic [31:0] hlpf_crc_byte(input logic [31:0] c, input logic [7:0] b);
    logic [31:0] r;
    r = c ^ {24'h000000, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

endpackage

// file: core/hlpf_uart.sv
// uart byte receiver and transmitter, 8n1, lsb first
`timescale 1ns/10ps
module hlpf_uart import hlpf_pkg::*; #(
  parameter int DIV = BAUD_DIV
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // line
  input wire logic rxd,
  output logic txd,
  // byte side
  output logic rx_valid,
  output logic [7:0] rx_data,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready
);
  logic [15:0] rcnt_q;
  logic [3:0] rbit_q;
  logic rbusy_q;
  logic [7:0] rsh_q;
  logic [15:0] tcnt_q;
  logic [3:0] tbit_q;
  logic tbusy_q;
  logic [8:0] tsh_q;
  wire rtick = rcnt_q == 16'h0000;
  wire ttick = tcnt_q == 16'h0000;

  assign tx_ready = !tbusy_q;

  // receive: sample each bit at its middle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rcnt_q <= 16'h0000;
      rbit_q <= 4'h0;
      rbusy_q <= 1'b0;
      rsh_q <= 8'h00;
      rx_valid <= 1'b0;
      rx_data <= 8'h00;
    end else begin
      rx_valid <= 1'b0;
      if (!rbusy_q) begin
        if (!rxd) begin
          rbusy_q <= 1'b1;
          rcnt_q <= 16'(DIV / 2);
          rbit_q <= 4'h0;
        end
      end else if (!rtick) begin
        rcnt_q <= rcnt_q - 16'h0001;
      end else begin
        rcnt_q <= 16'(DIV - 1);
        rbit_q <= rbit_q + 4'h1;
        if (rbit_q == 4'h0 && rxd) begin
          rbusy_q <= 1'b0;
        end else if (rbit_q == 4'h9) begin
          rbusy_q <= 1'b0;
          rx_valid <= rxd;
          rx_data <= rsh_q;
        end else if (rbit_q != 4'h0) begin
          rsh_q <= {rxd, rsh_q[7:1]};
        end
      end
    end
  end

  // transmit: start, eight data bits, one stop
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tcnt_q <= 16'h0000;
      tbit_q <= 4'h0;
      tbusy_q <= 1'b0;
      tsh_q <= 9'h1ff;
      txd <= 1'b1;
    end else if (!tbusy_q) begin
      if (tx_valid) begin
        tbusy_q <= 1'b1;
        txd <= 1'b0;
        tsh_q <= {1'b1, tx_data};
        tbit_q <= 4'h9;
        tcnt_q <= 16'(DIV - 1);
      end
    end else if (!ttick) begin
      tcnt_q <= tcnt_q - 16'h0001;
    end else begin
      tcnt_q <= 16'(DIV - 1);
      if (tbit_q == 4'h0) begin
        tbusy_q <= 1'b0;
      end else begin
        txd <= tsh_q[0];
        tsh_q <= {1'b1, tsh_q[8:1]};
        tbit_q <= tbit_q - 4'h1;
      end
    end
  end
endmodule // hlpf_uart

// file: core/hlpf_spi.sv
// spi mode 0 slave, msb first, clock sampled by the system clock
`timescale 1ns/10ps
module hlpf_spi import hlpf_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // pins
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe,
  // byte side
  output logic rx_valid,
  output logic [7:0] rx_data,
  input wire logic [7:0] tx_data,
  output logic tx_load
);
  logic sclk_q;
  logic cs_q;
  logic [2:0] bcnt_q;
  logic [7:0] rsh_q;
  logic [7:0] tsh_q;

  // edges of a mode 0 clock: sample on rise, shift on fall
  wire rise = !cs_n && sclk && !sclk_q;
  wire fall = !cs_n && !sclk && sclk_q;
  wire cs_fall = !cs_n && cs_q;
  assign tx_load = cs_fall || (rise && bcnt_q == 3'h7);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sclk_q <= 1'b0;
      cs_q <= 1'b1;
      miso_oe <= 1'b0;
      rx_valid <= 1'b0;
    end else begin
      sclk_q <= sclk;
      cs_q <= cs_n;
      miso_oe <= !cs_n;
      rx_valid <= rise && bcnt_q == 3'h7;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bcnt_q <= 3'h0;
      rsh_q <= 8'h00;
      rx_data <= 8'h00;
    end else if (cs_n) begin
      bcnt_q <= 3'h0;
    end else if (rise) begin
      rsh_q <= {rsh_q[6:0], mosi};
      bcnt_q <= bcnt_q + 3'h1;
      if (bcnt_q == 3'h7) begin
        rx_data <= {rsh_q[6:0], mosi};
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tsh_q <= 8'h00;
      miso <= 1'b0;
    end else if (cs_fall) begin
      miso <= tx_data[7];
      tsh_q <= {tx_data[6:0], 1'b0};
    end else if (tx_load) begin
      tsh_q <= tx_data;
    end else if (fall) begin
      miso <= tsh_q[7];
      tsh_q <= {tsh_q[6:0], 1'b0};
    end
  end
endmodule // hlpf_spi

// file: dv/hlpf_monitor.sv
// concurrent checks on the framer's pins and event outputs
`timescale 1ns/10ps
module hlpf_monitor import hlpf_pkg::*; #(
  parameter int DIV = BAUD_DIV
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // pins
  input wire logic uart_rxd,
  input wire logic uart_txd,
  input wire logic spi_cs_n,
  input wire logic spi_miso_oe,
  input wire logic irq,
  // events and transmit
  input wire hlpf_byte_s rx_byte,
  input wire logic msg_done,
  input wire logic rx_err,
  input wire hlpf_sel_e if_sel,
  input wire logic seg_start,
  input wire logic tx_busy
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // number of consecutive low samples on the uart output
  logic [15:0] low_q;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      low_q <= 16'h0000;
    end else if (!uart_txd) begin
      low_q <= low_q + 16'h0001;
    end else begin
      low_q <= 16'h0000;
    end
  end
  property p_sel_hold; (if_sel != SEL_NONE) |=> $stable(if_sel); endproperty
  a_sel_hold: assert property (p_sel_hold) else $error("interface choice changed");
  property p_sel_spi; (if_sel == SEL_NONE && !spi_cs_n) |=> (if_sel == SEL_SPI); endproperty
  a_sel_spi: assert property (p_sel_spi) else $error("spi not picked");
  property p_sel_uart;
    (if_sel == SEL_NONE && spi_cs_n && !uart_rxd) |=> (if_sel == SEL_UART);
  endproperty
  a_sel_uart: assert property (p_sel_uart) else $error("uart not picked");
  property p_oe_on; (!spi_cs_n && if_sel != SEL_UART) |=> spi_miso_oe; endproperty
  a_oe_on: assert property (p_oe_on) else $error("miso not driven while selected");
  property p_oe_off; spi_cs_n |=> !spi_miso_oe; endproperty
  a_oe_off: assert property (p_oe_off) else $error("miso driven while deselected");
  property p_irq_uart; (if_sel == SEL_UART) |-> !irq; endproperty
  a_irq_uart: assert property (p_irq_uart) else $error("interrupt raised in uart mode");
  property p_bit_len; $rose(uart_txd) |-> (low_q % DIV == 0); endproperty
  a_bit_len: assert property (p_bit_len) else $error("uart bit time wrong");
  property p_stop; !uart_txd |-> (low_q < 9 * DIV); endproperty
  a_stop: assert property (p_stop) else $error("uart stop bit missing");
  property p_last_done; (rx_byte.valid && rx_byte.last) |-> ##1 msg_done; endproperty
  a_last_done: assert property (p_last_done) else $error("message end not flagged");
  property p_done_cause; msg_done |-> $past(rx_byte.valid && rx_byte.last); endproperty
  a_done_cause: assert property (p_done_cause) else $error("message end without last");
  property p_busy; (seg_start && !tx_busy) |=> tx_busy; endproperty
  a_busy: assert property (p_busy) else $error("segment start not taken");
  c_done: cover property (msg_done);
  c_err: cover property (rx_err);
  c_spi: cover property (if_sel == SEL_SPI);
  c_busy: cover property (tx_busy);
endmodule // hlpf_monitor

bind hlpf_framer hlpf_monitor #(.DIV(DIV)) i_hlpf_monitor (
  .clk(clk), .nrst(nrst), .uart_rxd(uart_rxd), .uart_txd(uart_txd), .spi_cs_n(spi_cs_n),
  .spi_miso_oe(spi_miso_oe), .irq(irq), .rx_byte(rx_byte), .msg_done(msg_done),
  .rx_err(rx_err), .if_sel(if_sel), .seg_start(seg_start), .tx_busy(tx_busy)
);

// file: dv/hlpf_host_model.sv
// host-side uart peer: sends bytes to the framer and collects its answers
`timescale 1ns/10ps
module hlpf_host_model #(
  parameter int DIV = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // uart line
  output logic rxd,
  input wire logic txd
);
  logic [7:0] rxq[$];
  logic [7:0] b;
  int stop_bad = 0;
  initial rxd = 1'b1;
  task automatic send_byte(input logic [7:0] v);
    @(negedge clk);
    rxd = 1'b0;
    for (int i = 0; i < 9; i++) begin
      repeat (DIV) @(negedge clk);
      rxd = (i < 8) ? v[i] : 1'b1;
    end
    repeat (DIV) @(negedge clk);
  endtask
  // receiver samples near mid-bit
  always begin
    @(posedge clk);
    if (nrst === 1'b1 && txd === 1'b0) begin
      repeat (DIV / 2 - 1) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
        repeat (DIV) @(posedge clk);
        b[i] = txd;
      end
      repeat (DIV) @(posedge clk);
      if (txd !== 1'b1) stop_bad++;
      rxq.push_back(b);
    end
  end
endmodule // hlpf_host_model

// file: dv/host_link_packet_framer_tb.sv
// self-checking bench for the host link packet framer
`timescale 1ns/10ps
module host_link_packet_framer_tb;
  import hlpf_pkg::*;
  localparam int DIV = 4;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic spi_cs_n = 1'b1;
  logic spi_sclk = 1'b0;
  logic spi_mosi = 1'b0;
  logic use_spi = 1'b0;
  logic seg_start = 1'b0;
  logic usr_tx_valid = 1'b0;
  logic [7:0] usr_tx_data = 8'h00;
  hlpf_seg_s seg = '0;
  logic uart_rxd, uart_txd, spi_miso, spi_miso_oe, irq, msg_done, rx_err, usr_tx_ready, tx_busy;
  hlpf_byte_s rx_byte;
  hlpf_sel_e if_sel;
  int err_total = 0;
  int checks = 0;
  int n_done, n_err, n_last;
  logic [7:0] gotq[$];

  always #25 clk = ~clk;

  hlpf_framer #(.DIV(DIV)) i_hlpf_framer (
    .clk(clk), .nrst(nrst), .uart_rxd(uart_rxd), .uart_txd(uart_txd), .spi_sclk(spi_sclk),
    .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe),
    .irq(irq), .rx_byte(rx_byte), .msg_done(msg_done), .rx_err(rx_err), .if_sel(if_sel),
    .seg_start(seg_start), .seg(seg), .usr_tx_valid(usr_tx_valid), .usr_tx_data(usr_tx_data),
    .usr_tx_ready(usr_tx_ready), .tx_busy(tx_busy)
  );
  hlpf_host_model #(.DIV(DIV)) i_hlpf_host_model (
    .clk(clk), .nrst(nrst), .rxd(uart_rxd), .txd(uart_txd)
  );

  // collect released bytes and event pulses
  always @(posedge clk) begin
    if (rx_byte.valid === 1'b1) begin
      gotq.push_back(rx_byte.data);
      n_last += (rx_byte.last === 1'b1);
    end
    n_done += (msg_done === 1'b1);
    n_err += (rx_err === 1'b1);
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic complete_run;
    if (err_total == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic wait_rx(input int n);
    int k;
    k = 0;
    while (i_hlpf_host_model.rxq.size() < n && k < 20000) begin
      @(negedge clk);
      k++;
    end
    if (k >= 20000) begin
      err_total++;
      complete_run();
    end
  endtask
  task automatic clr;
    gotq.delete();
    n_done = 0;
    n_err = 0;
    n_last = 0;
  endtask
  function automatic logic [31:0] crc_calc(input logic [7:0] q[$]);
    logic [31:0] c;
    c = CRC_INIT;
    foreach (q[i]) begin
      c = c ^ {24'h000000, q[i]};
      for (int j = 0; j < 8; j++) begin
        c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
      end
    end
    return c ^ CRC_XOROUT;
  endfunction
  // mode 0 master byte, sclk at a quarter of the system clock
  task automatic spi_byte(input logic [7:0] v, output logic [7:0] r);
    for (int i = 7; i >= 0; i--) begin
      spi_mosi = v[i];
      repeat (2) @(negedge clk);
      spi_sclk = 1'b1;
      r[i] = spi_miso;
      repeat (2) @(negedge clk);
      spi_sclk = 1'b0;
    end
  endtask
  task automatic send_frame(input logic [7:0] pl[$], input logic bad);
    logic [31:0] c;
    logic [15:0] sz;
    logic [7:0] f[$];
    logic [7:0] r;
    c = crc_calc(pl) ^ {31'h0, bad};
    sz = 16'(pl.size());
    f = {CHAN_BYTE, CHAN_BYTE, sz[7:0], sz[15:8], pl, c[7:0], c[15:8], c[23:16], c[31:24]};
    foreach (f[i]) begin
      if (use_spi) begin
        spi_byte(f[i], r);
      end else begin
        i_hlpf_host_model.send_byte(f[i]);
      end
    end
  endtask
  task automatic send_chunk(input logic [15:0] nr, input logic [15:0] tot,
                            input logic [7:0] d[$], input logic bad);
    logic [15:0] ts;
    logic [7:0] pl[$];
    ts = 16'(d.size());
    pl = {ts[7:0], ts[15:8], nr[7:0], nr[15:8], tot[7:0], tot[15:8], d};
    send_frame(pl, bad);
  endtask
  task automatic expect_ack;
    wait_rx(4);
    repeat (200) @(negedge clk);
    chk(i_hlpf_host_model.rxq.size(), 4);
    chk({i_hlpf_host_model.rxq[0], i_hlpf_host_model.rxq[1], i_hlpf_host_model.rxq[2],
         i_hlpf_host_model.rxq[3]}, 32'h7fff017f);
    i_hlpf_host_model.rxq.delete();
  endtask

  task automatic t_multi_chunk;
    clr();
    send_chunk(16'h0001, 16'h0002, {8'ha5}, 1'b0);
    expect_ack();
    chk(n_done, 0);
    send_chunk(16'h0002, 16'h0002, {8'h3c, 8'hc3}, 1'b0);
    expect_ack();
    chk({8'(gotq.size()), gotq[0], gotq[1], gotq[2]}, 32'h03a53cc3);
    chk({8'(n_last), 8'(n_done), 8'(n_err)}, 24'h010100);
    chk(if_sel, SEL_UART);
  endtask
  task automatic t_bad_crc;
    clr();
    send_chunk(16'h0001, 16'h0001, {8'h55}, 1'b1);
    expect_ack();
    chk(n_err, 1);
    chk(gotq.size() + n_done, 0);
  endtask
  task automatic t_out_of_order;
    clr();
    send_chunk(16'h0002, 16'h0002, {8'h66}, 1'b0);
    expect_ack();
    chk(n_err, 1);
    chk(gotq.size(), 0);
  endtask
  task automatic t_limits;
    logic [7:0] d[$];
    for (int i = 0; i < 243; i++) d.push_back(8'(i));
    clr();
    send_chunk(16'h0001, 16'h0001, d, 1'b0);
    expect_ack();
    chk(n_err, 1);
    chk(gotq.size(), 0);
    d.pop_back();
    clr();
    send_chunk(16'h0001, 16'h0001, d, 1'b0);
    expect_ack();
    chk(gotq.size(), 242);
    chk({gotq[241], 8'(n_done), 8'(n_err)}, 24'hf10100);
  endtask
  task automatic t_transmit;
    logic [7:0] ex[$];
    logic [31:0] c;
    int k;
    ex = {8'h02, 8'h00, 8'h01, 8'h00, 8'h01, 8'h00, 8'h11, 8'h22};
    c = crc_calc(ex);
    ex = {8'h00, 8'h00, 8'h08, 8'h00, ex, c[7:0], c[15:8], c[23:16], c[31:24]};
    seg = '{total: 16'h0001, nr: 16'h0001, len: 16'h0002};
    seg_start = 1'b1;
    @(negedge clk);
    seg_start = 1'b0;
    for (int i = 0; i < 2; i++) begin
      usr_tx_valid = 1'b1;
      usr_tx_data = i ? 8'h22 : 8'h11;
      k = 0;
      while (usr_tx_ready !== 1'b1 && k < 5000) begin
        @(negedge clk);
        k++;
      end
      if (k >= 5000) begin
        err_total++;
        complete_run();
      end
      @(negedge clk);
    end
    usr_tx_valid = 1'b0;
    wait_rx(ex.size());
    foreach (ex[i]) begin
      chk(i_hlpf_host_model.rxq[i], ex[i]);
    end
    chk(i_hlpf_host_model.stop_bad, 0);
  endtask
  task automatic t_spi_select;
    logic [7:0] r[4];
    nrst = 1'b0;
    repeat (20) @(negedge clk);
    nrst = 1'b1;
    chk(if_sel, SEL_NONE);
    spi_cs_n = 1'b0;
    repeat (2) @(negedge clk);
    chk({if_sel, spi_miso_oe}, {SEL_SPI, 1'b1});
    i_hlpf_host_model.send_byte(8'h00);
    chk(if_sel, SEL_SPI);
    spi_cs_n = 1'b1;
    repeat (2) @(negedge clk);
    chk(spi_miso_oe, 0);
    clr();
    use_spi = 1'b1;
    spi_cs_n = 1'b0;
    send_chunk(16'h0001, 16'h0001, {8'h5a}, 1'b0);
    spi_cs_n = 1'b1;
    repeat (10) @(negedge clk);
    chk({irq, 8'(gotq.size()), gotq[0], 8'(n_done)}, 25'h1015a01);
    spi_cs_n = 1'b0;
    foreach (r[i]) begin
      spi_byte(8'h00, r[i]);
    end
    spi_cs_n = 1'b1;
    repeat (4) @(negedge clk);
    chk({r[0], r[1], r[2], r[3]}, 32'h7fff017f);
    chk(irq, 0);
  endtask

  initial begin
    repeat (20) @(negedge clk);
    chk({uart_txd, if_sel, tx_busy, irq, spi_miso_oe}, 6'h20);
    nrst = 1'b1;
    t_multi_chunk();
    t_bad_crc();
    t_out_of_order();
    t_limits();
    t_transmit();
    t_spi_select();
    complete_run();
  end
endmodule // host_link_packet_framer_tb
